// ==== irxbm_defines.svh ====
// constants of the iso receive mask and bus-management init register block
// Notes on behaviour
// RULE_01 - four-bit receive mask, upper bits read zero
// RULE_02 - set and clear addresses both read mask
// RULE_03 - mask bit n governs receive context n
// RULE_04 - ones set or clear; zeros do nothing
// RULE_05 - event clear read returns events ANDed mask
// RULE_06 - summary request when event and mask meet
// RULE_07 - bandwidth field resets 1333h, survives bus reset
// RULE_08 - any reset kind copies bandwidth to CSR; soft_reset_input gives no load here
// RULE_09 - bandwidth bits 31..13 ignore writes, read zero
// RULE_10 - upper channels resets ones, copied on resets
// RULE_11 - lower channels resets ones, copied on resets
`ifndef IRXBM_DEFINES_SVH
`define IRXBM_DEFINES_SVH

// ************************************************************
// widths
// ************************************************************
`define IRXBM_ADDR_W       8
`define IRXBM_DATA_W       32
`define IRXBM_STRB_W       4
`define IRXBM_CTX_N        4
`define IRXBM_BW_W         13
`define IRXBM_IRQ_N        2

// ************************************************************
// byte offsets of the register words
// ************************************************************
`define IRXBM_ADDR_ALIGN   8'hFC
`define IRXBM_OFS_EVT_CLR  8'hA4
`define IRXBM_OFS_MASK_SET 8'hA8
`define IRXBM_OFS_MASK_CLR 8'hAC
`define IRXBM_OFS_INIT_BW  8'hB0
`define IRXBM_OFS_INIT_HI  8'hB4
`define IRXBM_OFS_INIT_LO  8'hB8
`define IRXBM_OFS_IRQ_STAT 8'hC0
`define IRXBM_OFS_IRQ_MASK 8'hC4

// ************************************************************
// reset values, interrupt bits, responses
// ************************************************************
`define IRXBM_BW_RST       13'h1333
`define IRXBM_CH_RST       32'hFFFFFFFF
`define IRXBM_IRQ_SUMMARY  0
`define IRXBM_IRQ_CSRLOAD  1
`define IRXBM_RESP_OKAY    2'h0
`define IRXBM_RESP_SLVERR  2'h2

`endif

// ==== irxbm_pkg.sv ====
// types shared by the iso receive mask and bus-management init register block
`include "irxbm_defines.svh"
package irxbm_pkg;

   // ************************************************************
   // carriers
   // ************************************************************
   // one captured write: address, data and byte enables
   typedef struct packed {
      logic [`IRXBM_ADDR_W-1:0] addr;
      logic [`IRXBM_DATA_W-1:0] data;
      logic [`IRXBM_STRB_W-1:0] strb;
   } irxbm_wr_t;

   // values handed to the bus-management CSR block on a load
   typedef struct packed {
      logic [`IRXBM_BW_W-1:0]   bandwidth;
      logic [`IRXBM_DATA_W-1:0] upper;
      logic [`IRXBM_DATA_W-1:0] lower;
   } irxbm_csr_init_t;

endpackage

// ==== irxbm_sticky.sv ====
// set/clear bit register where a set always beats a clear in the same cycle
`timescale 1ns/10ps
module irxbm_sticky #(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // bit controls, one-cycle
   input  wire logic [W-1:0] set_bits,
   input  wire logic [W-1:0] clr_bits,
   // stored bits
   output logic      [W-1:0] bits
);

   logic [W-1:0] bits_reg;
   logic [W-1:0] bits_next;

   // ************************************************************
   // next value
   // ************************************************************
   // set applied last so a coincident event is never lost
   always_comb begin
      bits_next = (bits_reg & ~clr_bits) | set_bits;
   end

   // ************************************************************
   // storage
   // ************************************************************
   // reset leaves every bit clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bits_reg <= '0;
      end else begin
         bits_reg <= bits_next;
      end
   end

   assign bits = bits_reg;

endmodule

// ==== irxbm_regs.sv ====
// iso receive interrupt mask and bus-management init registers on AXI4-Lite
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "irxbm_defines.svh"
module irxbm_regs (
   // clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // write address channel
   input  wire logic [`IRXBM_ADDR_W-1:0]      awaddr,
   input  wire logic [2:0]                    awprot,
   input  wire logic                          awvalid,
   output logic                               awready,
   // write data channel
   input  wire logic [`IRXBM_DATA_W-1:0]      wdata,
   input  wire logic [`IRXBM_STRB_W-1:0]      wstrb,
   input  wire logic                          wvalid,
   output logic                               wready,
   // write response channel
   output logic [1:0]                         bresp,
   output logic                               bvalid,
   input  wire logic                          bready,
   // read address channel
   input  wire logic [`IRXBM_ADDR_W-1:0]      araddr,
   input  wire logic [2:0]                    arprot,
   input  wire logic                          arvalid,
   output logic                               arready,
   // read data channel
   output logic [`IRXBM_DATA_W-1:0]           rdata,
   output logic [1:0]                         rresp,
   output logic                               rvalid,
   input  wire logic                          rready,
   // receive context events from the event register block
   input  wire logic [`IRXBM_CTX_N-1:0]       rx_event,
   // reset sources
   input  wire logic                          soft_reset_input,
   input  wire logic                          global_reset_input,
   input  wire logic                          host_bus_reset_input,
   input  wire logic                          bus_reset_1394_input,
   // summary request toward the main interrupt event register
   output logic                               iso_receive_summary_irq,
   // load toward the bus-management CSR block
   output logic                               csr_load_strobe,
   output irxbm_pkg::irxbm_csr_init_t         csr_init_value,
   // block interrupt
   output logic                               irq
);

   // ************************************************************
   // declarations
   // ************************************************************
   // bus handshake state
   logic                              aw_full_reg;
   logic                              aw_full_next;
   logic                              w_full_reg;
   logic                              w_full_next;
   irxbm_pkg::irxbm_wr_t              wr_reg;
   irxbm_pkg::irxbm_wr_t              wr_next;
   logic                              awready_reg;
   logic                              awready_next;
   logic                              wready_reg;
   logic                              wready_next;
   logic                              bvalid_reg;
   logic                              bvalid_next;
   logic [1:0]                        bresp_reg;
   logic [1:0]                        bresp_next;
   logic                              arready_reg;
   logic                              arready_next;
   logic                              rvalid_reg;
   logic                              rvalid_next;
   logic [1:0]                        rresp_reg;
   logic [1:0]                        rresp_next;
   logic [`IRXBM_DATA_W-1:0]          rdata_reg;
   logic [`IRXBM_DATA_W-1:0]          rdata_next;
   logic                              wr_fire;
   logic [`IRXBM_ADDR_W-1:0]          wr_word;
   logic [`IRXBM_ADDR_W-1:0]          rd_word;
   logic [`IRXBM_DATA_W-1:0]          wmask;
   logic [`IRXBM_DATA_W-1:0]          wbits;
   // init fields
   logic [`IRXBM_BW_W-1:0]            bw_reg;
   logic [`IRXBM_BW_W-1:0]            bw_next;
   logic [`IRXBM_DATA_W-1:0]          hi_reg;
   logic [`IRXBM_DATA_W-1:0]          hi_next;
   logic [`IRXBM_DATA_W-1:0]          lo_reg;
   logic [`IRXBM_DATA_W-1:0]          lo_next;
   // masks and interrupts
   logic [`IRXBM_CTX_N-1:0]           mask_bits;
   logic [`IRXBM_CTX_N-1:0]           mask_set;
   logic [`IRXBM_CTX_N-1:0]           mask_clr;
   logic [`IRXBM_IRQ_N-1:0]           stat_bits;
   logic [`IRXBM_IRQ_N-1:0]           stat_set;
   logic [`IRXBM_IRQ_N-1:0]           stat_clr;
   logic [`IRXBM_IRQ_N-1:0]           imask_reg;
   logic [`IRXBM_IRQ_N-1:0]           imask_next;
   logic                              summary_reg;
   logic                              summary_next;
   logic                              irq_reg;
   logic                              irq_next;
   // csr load
   logic                              load_pend_reg;
   logic                              load_pend_next;
   logic                              load_req;
   logic                              load_req_d_reg;
   logic                              load_req_d_next;
   logic                              load_reg;
   logic                              load_next;
   irxbm_pkg::irxbm_csr_init_t        csr_reg;
   irxbm_pkg::irxbm_csr_init_t        csr_next;

   // ************************************************************
   // write and read channels
   // ************************************************************
   // address and data are taken in either order; the write acts once both are held
   // and no response is pending, so one write at most is under way
   always_comb begin
      aw_full_next = aw_full_reg;
      w_full_next  = w_full_reg;
      wr_next      = wr_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      wr_fire      = aw_full_reg && w_full_reg && !bvalid_reg;
      wr_word      = wr_reg.addr & `IRXBM_ADDR_ALIGN;
      if (awvalid && awready_reg) begin
         aw_full_next = 1'b1;
         wr_next.addr = awaddr;
      end
      if (wvalid && wready_reg) begin
         w_full_next  = 1'b1;
         wr_next.data = wdata;
         wr_next.strb = wstrb;
      end
      if (bvalid_reg && bready) begin
         bvalid_next = 1'b0;
      end
      if (wr_fire) begin
         aw_full_next = 1'b0;
         w_full_next  = 1'b0;
         bvalid_next  = 1'b1;
         case (wr_word)
            `IRXBM_OFS_EVT_CLR,
            `IRXBM_OFS_MASK_SET,
            `IRXBM_OFS_MASK_CLR,
            `IRXBM_OFS_INIT_BW,
            `IRXBM_OFS_INIT_HI,
            `IRXBM_OFS_INIT_LO,
            `IRXBM_OFS_IRQ_STAT,
            `IRXBM_OFS_IRQ_MASK: begin
               bresp_next = `IRXBM_RESP_OKAY;
            end
            default: begin
               bresp_next = `IRXBM_RESP_SLVERR;
            end
         endcase
      end
      awready_next = !aw_full_next;
      wready_next  = !w_full_next;
   end

   // byte enables turned into a bit mask; the words are written lane by lane
   assign wmask = {{8{wr_reg.strb[3]}}, {8{wr_reg.strb[2]}},
                   {8{wr_reg.strb[1]}}, {8{wr_reg.strb[0]}}};
   assign wbits = wr_reg.data & wmask;

   // read data is sampled from the registers on the address handshake
   always_comb begin
      rvalid_next  = rvalid_reg;
      rresp_next   = rresp_reg;
      rdata_next   = rdata_reg;
      rd_word      = araddr & `IRXBM_ADDR_ALIGN;
      if (rvalid_reg && rready) begin
         rvalid_next = 1'b0;
      end
      if (arvalid && arready_reg) begin
         rvalid_next = 1'b1;
         rresp_next  = `IRXBM_RESP_OKAY;
         case (rd_word)
            `IRXBM_OFS_EVT_CLR: begin
               rdata_next = {{(`IRXBM_DATA_W-`IRXBM_CTX_N){1'b0}},
                             rx_event & mask_bits}; // see RULE_05
            end
            `IRXBM_OFS_MASK_SET,
            `IRXBM_OFS_MASK_CLR: begin
               rdata_next = {{(`IRXBM_DATA_W-`IRXBM_CTX_N){1'b0}},
                             mask_bits}; // see RULE_01 see RULE_02
            end
            `IRXBM_OFS_INIT_BW: begin
               rdata_next = {{(`IRXBM_DATA_W-`IRXBM_BW_W){1'b0}}, bw_reg}; // see RULE_09
            end
            `IRXBM_OFS_INIT_HI: begin
               rdata_next = hi_reg;
            end
            `IRXBM_OFS_INIT_LO: begin
               rdata_next = lo_reg;
            end
            `IRXBM_OFS_IRQ_STAT: begin
               rdata_next = {{(`IRXBM_DATA_W-`IRXBM_IRQ_N){1'b0}}, stat_bits};
            end
            `IRXBM_OFS_IRQ_MASK: begin
               rdata_next = {{(`IRXBM_DATA_W-`IRXBM_IRQ_N){1'b0}}, imask_reg};
            end
            default: begin
               rdata_next = '0;
               rresp_next = `IRXBM_RESP_SLVERR;
            end
         endcase
      end
      arready_next = !rvalid_next;
   end

   // ************************************************************
   // init fields and mask controls
   // ************************************************************
   // soft reset outranks a write in the same cycle; bus resets do not touch the fields
   always_comb begin
      bw_next    = bw_reg;
      hi_next    = hi_reg;
      lo_next    = lo_reg;
      imask_next = imask_reg;
      mask_set   = '0;
      mask_clr   = '0;
      stat_clr   = '0;
      if (wr_fire) begin
         case (wr_word)
            `IRXBM_OFS_MASK_SET: begin
               mask_set = wbits[`IRXBM_CTX_N-1:0]; // see RULE_04 see RULE_03
            end
            `IRXBM_OFS_MASK_CLR: begin
               mask_clr = wbits[`IRXBM_CTX_N-1:0]; // see RULE_04
            end
            `IRXBM_OFS_INIT_BW: begin
               bw_next = (bw_reg & ~wmask[`IRXBM_BW_W-1:0])
                         | wbits[`IRXBM_BW_W-1:0]; // see RULE_09
            end
            `IRXBM_OFS_INIT_HI: begin
               hi_next = (hi_reg & ~wmask) | wbits;
            end
            `IRXBM_OFS_INIT_LO: begin
               lo_next = (lo_reg & ~wmask) | wbits;
            end
            `IRXBM_OFS_IRQ_STAT: begin
               stat_clr = wbits[`IRXBM_IRQ_N-1:0];
            end
            `IRXBM_OFS_IRQ_MASK: begin
               imask_next = (imask_reg & ~wmask[`IRXBM_IRQ_N-1:0])
                            | wbits[`IRXBM_IRQ_N-1:0];
            end
            default: begin
               bw_next = bw_reg;
            end
         endcase
      end
      if (soft_reset_input) begin
         bw_next = `IRXBM_BW_RST;  // see RULE_07
         hi_next = `IRXBM_CH_RST;  // see RULE_10
         lo_next = `IRXBM_CH_RST;  // see RULE_11
      end
   end

   // receive mask; only one of the two addresses acts in a cycle
   irxbm_sticky #(
      .W (`IRXBM_CTX_N)
   ) u_rx_mask (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .set_bits (mask_set),
      .clr_bits (mask_clr),
      .bits     (mask_bits)
   );

   // ************************************************************
   // summary request, csr load and block interrupt
   // ************************************************************
   // a rise of the OR of the global, host-bus and 1394 reset inputs gives one load, soft reset none; a load is also owed right after reset
   always_comb begin
      summary_next    = |(rx_event & mask_bits); // see RULE_06 see RULE_03
      load_req        = global_reset_input | host_bus_reset_input
                        | bus_reset_1394_input;
      load_req_d_next = load_req;
      load_pend_next  = 1'b0;
      load_next       = load_pend_reg | (load_req & ~load_req_d_reg); // see RULE_08
      csr_next        = csr_reg;
      if (load_next) begin
         csr_next.bandwidth = bw_reg;  // see RULE_08
         csr_next.upper     = hi_reg;  // see RULE_10
         csr_next.lower     = lo_reg;  // see RULE_11
      end
      stat_set                     = '0;
      stat_set[`IRXBM_IRQ_SUMMARY] = summary_next & ~summary_reg;
      stat_set[`IRXBM_IRQ_CSRLOAD] = load_next;
      // status flops update on this same edge, so irq follows them with no lag
      irq_next = |(((stat_bits & ~stat_clr) | stat_set) & imask_next);
   end

   // event status; clearing by writing ones, a fresh event wins
   irxbm_sticky #(
      .W (`IRXBM_IRQ_N)
   ) u_irq_stat (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .set_bits (stat_set),
      .clr_bits (stat_clr),
      .bits     (stat_bits)
   );

   // ************************************************************
   // registers
   // ************************************************************
   // synchronous reset; the bus sits ready to take requests once it is released
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg    <= 1'b0;
         w_full_reg     <= 1'b0;
         wr_reg         <= '0;
         awready_reg    <= 1'b1;
         wready_reg     <= 1'b1;
         bvalid_reg     <= 1'b0;
         bresp_reg      <= `IRXBM_RESP_OKAY;
         arready_reg    <= 1'b1;
         rvalid_reg     <= 1'b0;
         rresp_reg      <= `IRXBM_RESP_OKAY;
         rdata_reg      <= '0;
         bw_reg         <= `IRXBM_BW_RST;  // see RULE_07
         hi_reg         <= `IRXBM_CH_RST;  // see RULE_10
         lo_reg         <= `IRXBM_CH_RST;  // see RULE_11
         imask_reg      <= '0;
         summary_reg    <= 1'b0;
         irq_reg        <= 1'b0;
         load_pend_reg  <= 1'b1;
         load_req_d_reg <= 1'b0;
         load_reg       <= 1'b0;
         csr_reg        <= {`IRXBM_BW_RST, `IRXBM_CH_RST, `IRXBM_CH_RST};
      end else begin
         aw_full_reg    <= aw_full_next;
         w_full_reg     <= w_full_next;
         wr_reg         <= wr_next;
         awready_reg    <= awready_next;
         wready_reg     <= wready_next;
         bvalid_reg     <= bvalid_next;
         bresp_reg      <= bresp_next;
         arready_reg    <= arready_next;
         rvalid_reg     <= rvalid_next;
         rresp_reg      <= rresp_next;
         rdata_reg      <= rdata_next;
         bw_reg         <= bw_next;
         hi_reg         <= hi_next;
         lo_reg         <= lo_next;
         imask_reg      <= imask_next;
         summary_reg    <= summary_next;
         irq_reg        <= irq_next;
         load_pend_reg  <= load_pend_next;
         load_req_d_reg <= load_req_d_next;
         load_reg       <= load_next;
         csr_reg        <= csr_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign awready                 = awready_reg;
   assign wready                  = wready_reg;
   assign bvalid                  = bvalid_reg;
   assign bresp                   = bresp_reg;
   assign arready                 = arready_reg;
   assign rvalid                  = rvalid_reg;
   assign rresp                   = rresp_reg;
   assign rdata                   = rdata_reg;
   assign iso_receive_summary_irq = summary_reg;
   assign csr_load_strobe         = load_reg;
   assign csr_init_value          = csr_reg;
   assign irq                     = irq_reg;

endmodule

// ==== irxbm_regs_props.sv ====
// concurrent checks on the ports of the iso receive mask and init register block
`timescale 1ns/10ps
module irxbm_regs_props (
   // clock and reset
   input logic        aclk,
   input logic        aresetn,
   // bus handshakes
   input logic        awvalid,
   input logic        awready,
   input logic        wvalid,
   input logic        wready,
   input logic        bvalid,
   input logic        arvalid,
   input logic        arready,
   input logic        rvalid,
   input logic        rready,
   input logic [31:0] rdata,
   // events, reset sources and block outputs
   input logic [3:0]  rx_event,
   input logic        global_reset_input,
   input logic        host_bus_reset_input,
   input logic        bus_reset_1394_input,
   input logic        iso_receive_summary_irq,
   input logic        csr_load_strobe,
   input logic [76:0] csr_init_value
);
   // ************************
   // properties
   // ************************
   logic any_reset;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // the three load causes act as one level
   assign any_reset = global_reset_input | host_bus_reset_input | bus_reset_1394_input;
   a_summary_idle: assert property (!(|rx_event) |=> !iso_receive_summary_irq)
      else $error("summary without any event");
   a_load_on_rise: assert property ($rose(any_reset) |=> csr_load_strobe)
      else $error("no load after a reset input rose");
   a_load_single: assert property (csr_load_strobe |=> !csr_load_strobe)
      else $error("load strobe too long");
   // a held input gives no reload; the past guard spares the owed load
   a_load_held: assert property ($past(aresetn) && any_reset && $past(any_reset)
      |=> !csr_load_strobe)
      else $error("reload while input held");
   a_value_steady: assert property ($past(aresetn) && !csr_load_strobe
      |-> $stable(csr_init_value))
      else $error("init value moved without a load");
   a_write_answer: assert property (awvalid && awready && wvalid && wready
      && !bvalid |-> ##2 bvalid)
      else $error("write response late");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_read_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
endmodule

// ==== irxbm_regs_test.sv ====
// self-checking bench for the iso receive mask and init register block
`timescale 1ns/10ps
`include "irxbm_defines.svh"
module irxbm_regs_test;
   // ************************
   // signals and reference model
   // ************************
   logic                       aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic                       arvalid, arready, rvalid, rready, summ, strobe, irq, sp;
   logic                       soft_rst, glob_rst, host_rst, bus_rst;
   logic [7:0]                 awaddr, araddr;
   logic [31:0]                wdata, rdata, hi, lo;
   logic [3:0]                 wstrb, rx_event, mk;
   logic [1:0]                 bresp, rresp, st, im;
   logic [12:0]                bw;
   irxbm_pkg::irxbm_csr_init_t csr;
   int                         fails, cmp_count;
   logic [7:0] addrs [9] = '{8'hA4, 8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hC0, 8'hC4, 8'h10};

   irxbm_regs irxbm_regs_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rx_event(rx_event), .soft_reset_input(soft_rst),
      .global_reset_input(glob_rst), .host_bus_reset_input(host_rst),
      .bus_reset_1394_input(bus_rst), .iso_receive_summary_irq(summ),
      .csr_load_strobe(strobe), .csr_init_value(csr), .irq(irq));

   // model after reset; bit1 is set by the load owed on release
   function automatic void mrst();
      mk = 4'h0;
      bw = `IRXBM_BW_RST;
      hi = `IRXBM_CH_RST;
      lo = `IRXBM_CH_RST;
      st = 2'h2;
      im = 2'h0;
      sp = 1'b0;
   endfunction
   function automatic logic [1:0] ok(input logic [7:0] a);
      return (a inside {[8'hA4:8'hBB], [8'hC0:8'hC7]}) ? `IRXBM_RESP_OKAY : `IRXBM_RESP_SLVERR;
   endfunction
   function automatic logic [31:0] mexp(input logic [7:0] a);
      case (a)
         8'hA4: return {28'h0, rx_event & mk};
         8'hA8, 8'hAC: return {28'h0, mk};
         8'hB0: return {19'h0, bw};
         8'hB4: return hi;
         8'hB8: return lo;
         8'hC0: return {30'h0, st};
         8'hC4: return {30'h0, im};
         default: return 32'h0;
      endcase
   endfunction
   // bit0 follows a rising summary
   function automatic void upd();
      if ((|(rx_event & mk)) && !sp) st[0] = 1'b1;
      sp = |(rx_event & mk);
   endfunction
   // one accepted write, by byte lanes
   function automatic void mwr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] l, m;
      l = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      m = l & d;
      case (a)
         8'hA8: mk = mk | m[3:0];
         8'hAC: mk = mk & ~m[3:0];
         8'hB0: bw = (bw & ~l[12:0]) | m[12:0];
         8'hB4: hi = (hi & ~l) | m;
         8'hB8: lo = (lo & ~l) | m;
         8'hC0: st = st & ~m[1:0];
         8'hC4: im = (im & ~l[1:0]) | m[1:0];
         default: ;
      endcase
      upd();
   endfunction

   // ************************
   // bus and check tasks
   // ************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // bready stays high; the answer is taken at the edge it is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      mwr(a, d, s);
      check({30'h0, bresp}, {30'h0, ok(a)});
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'($urandom);
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && !rready) rready <= 1'b1;
      end while (!(rvalid && rready));
      check(rdata, mexp(a));
      check({30'h0, rresp}, {30'h0, ok(a)});
   endtask
   task automatic chk_all();
      foreach (addrs[i]) rd(addrs[i]);
      @(posedge aclk);
      check({31'h0, summ}, {31'h0, |(rx_event & mk)});
      check({31'h0, irq}, {31'h0, |(st & im)}); // block interrupt level
   endtask
   task automatic ev(input logic [3:0] v);
      rx_event <= v;
      repeat (2) @(posedge aclk);
      upd();
   endtask
   // k picks global, host-bus or 1394 bus reset
   task automatic pulse(input int k);
      @(posedge aclk);
      {glob_rst, host_rst, bus_rst} <= 3'(3'h4 >> k);
      repeat (2) @(posedge aclk);
      check({31'h0, strobe}, 32'h1);
      check({19'h0, csr.bandwidth}, {19'h0, bw});
      check(csr.upper, hi);
      check(csr.lower, lo);
      st[1] = 1'b1;
      @(posedge aclk);
      check({31'h0, strobe}, 32'h0);
      {glob_rst, host_rst, bus_rst} <= 3'h0;
   endtask
   task automatic reset_dut();
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      mrst();
      repeat (3) @(posedge aclk);
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ************************
   // clock, watchdog and test sequence
   // ************************
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   // the run needs far fewer cycles
   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      results();
   end
   initial begin
      {aresetn, awvalid, wvalid, arvalid, soft_rst, glob_rst, host_rst, bus_rst} = 8'h00;
      {awaddr, araddr, wdata, wstrb, rx_event} = 56'h0;
      {bready, rready} = 2'h3;
      fails = 0;
      cmp_count = 0;
      void'($urandom(75));
      reset_dut();
      chk_all();
      $display("test reset values done");
      repeat (60) begin
         wr(addrs[$urandom_range(8)], $urandom, 4'($urandom));
         if ($urandom_range(2) == 0) ev(4'($urandom));
         chk_all();
      end
      $display("test random access done");
      wr(8'hC4, 32'h3, 4'hF);
      wr(8'hB0, $urandom, 4'hF);
      for (int k = 0; k < 3; k++) begin
         pulse(k);
         chk_all();
      end
      wr(8'hC0, 32'h3, 4'hF);
      @(posedge aclk);
      soft_rst <= 1'b1;
      @(posedge aclk);
      soft_rst <= 1'b0;
      {bw, hi, lo} = {`IRXBM_BW_RST, `IRXBM_CH_RST, `IRXBM_CH_RST};
      chk_all();
      check({31'h0, strobe}, 32'h0); // soft reset loads nothing
      $display("test loads and interrupt done");
      reset_dut();
      chk_all();
      $display("test second reset done");
      results();
   end
endmodule

bind irxbm_regs irxbm_regs_props irxbm_regs_props_i (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .rx_event(rx_event), .global_reset_input(global_reset_input),
   .host_bus_reset_input(host_bus_reset_input), .bus_reset_1394_input(bus_reset_1394_input),
   .iso_receive_summary_irq(iso_receive_summary_irq), .csr_load_strobe(csr_load_strobe),
   .csr_init_value(csr_init_value));
